// [adcp_defs.svh]
`ifndef ADCP_DEFS_SVH
`define ADCP_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing.
// ----------------------------------------------------------------
`define ADCP_CLK_NS        100
`define ADCP_SCLK_HALF_NS  400
`define ADCP_RST_PULSE_NS  1000
`define ADCP_SCLK_HALF_CYC ((`ADCP_SCLK_HALF_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS)
`define ADCP_RST_CYC       ((`ADCP_RST_PULSE_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS)
`define ADCP_TMR_W         8

// ----------------------------------------------------------------
// Serial programming word.
// ----------------------------------------------------------------
`define ADCP_ADDR_W        8
`define ADCP_DATA_W        8
`define ADCP_WORD_W        16
`define ADCP_CNT_W         5
`define ADCP_CNT_FULL      5'h10
`define ADCP_CNT_OVER      5'h11
`define ADCP_REG_CNT       8
`define ADCP_REG_RST       8'h00
`define ADCP_SW_RST_ADDR   8'h00
`define ADCP_SW_RST_BIT    0
`define ADCP_MODE_IDX      1
`define ADCP_MODE_SKEW     0
`define ADCP_MODE_SYNC     1
`define ADCP_MODE_PDN      2
`define ADCP_MODE_GAIN     3
`define ADCP_MODE_EXTREF   4

// ----------------------------------------------------------------
// Pin vector layout and codes.
// ----------------------------------------------------------------
`define ADCP_PIN_W         11
`define ADCP_PIN_RSTV      11'h008
`define ADCP_PIN_RST       0
`define ADCP_PIN_SCLK      1
`define ADCP_PIN_SERIAL_DATA_IN     2
`define ADCP_PIN_SEN       3
`define ADCP_PIN_PDN       4
`define ADCP_PIN_LINK      5
`define ADCP_PIN_SER       7
`define ADCP_PIN_FMT       9
`define ADCP_PAR_NORMAL    2'h0
`define ADCP_PAR_SKEW      2'h1
`define ADCP_PAR_SYNC      2'h2
`define ADCP_PAR_PDN       2'h3
`define ADCP_LINK_1W_DDR   2'h0
`define ADCP_LINK_1W_SDR   2'h1
`define ADCP_LINK_2W_SDR   2'h2
`define ADCP_LINK_2W_DDR   2'h3
`define ADCP_SER_12X_RISE  2'h0
`define ADCP_SER_14X_RISE  2'h1
`define ADCP_SER_14X_FALL  2'h2
`define ADCP_SER_12X_FALL  2'h3
`define ADCP_FMT_OFFBIN    0
`define ADCP_FMT_LSBFIRST  1

// ----------------------------------------------------------------
// Host command registers.
// ----------------------------------------------------------------
`define ADCP_BUS_AW        4
`define ADCP_BUS_DW        32
`define ADCP_HREG_CTRL     4'h0
`define ADCP_HREG_STRAP    4'h1
`define ADCP_HREG_CMD      4'h2
`define ADCP_HREG_RESET    4'h3
`define ADCP_HREG_STATUS   4'h4
`define ADCP_CTRL_W        4
`define ADCP_CTRL_RST      4'h0
`define ADCP_STRAP_W       7
`define ADCP_STRAP_RST     7'h00

`endif

// [adcp_pkg.sv]
`default_nettype none

package adcp_pkg;

  typedef enum logic [0:0] {RX_IDLE, RX_SHIFT} adcp_rx_state_t;

  typedef enum logic [2:0] {
    HS_PULSE,
    HS_IDLE,
    HS_LEAD,
    HS_LOW,
    HS_HIGH,
    HS_TAIL
  } adcp_host_state_t;

endpackage

`default_nettype wire

// [adcp_ctl_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface adcp_ctl_if;
  logic       resetIn;
  logic       serialClk;
  logic       serialData;
  logic       serialEnable;
  logic       powerdownPin;
  logic [1:0] linkCfg;
  logic [1:0] serCfg;
  logic [1:0] fmtCfg;

  modport device (
    input resetIn,
    input serialClk,
    input serialData,
    input serialEnable,
    input powerdownPin,
    input linkCfg,
    input serCfg,
    input fmtCfg
  );

  modport host (
    output resetIn,
    output serialClk,
    output serialData,
    output serialEnable,
    output powerdownPin,
    output linkCfg,
    output serCfg,
    output fmtCfg
  );
endinterface

`default_nettype wire

// [adcp_dev_end.sv]
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "adcp_defs.svh"
// Overview of operation
// RL1: Reset low: shared clock pin clocks serial port.
// RL2: Reset low: shared data pin carries serial data.
// RL3: Reset low: enable pin frames serial transfers.
// RL4: Reset high: clock and data pins pick modes.
// RL5: Reset high: enable pin picks gain, reference.
// RL6: Controller initialises registers by reset pulse.
// RL7: Parallel mode needs reset held high always.
// RL8: Link pin picks wire count and clocking.
// RL9: Grounded link pin means 1-wire DDR.
// RL10: Serialization pin picks factor and capture edge.
// RL11: DDR 12x: both pin levels behave alike.
// RL12: Power-down pin powers down all channels.
// RL13: Format pin picks coding and bit order.
// RL14: Pin roles follow reset level, no extra sampling.

module adcp_dev_end #(
  parameter int REG_CNT = `ADCP_REG_CNT
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  // Control pins
  adcp_ctl_if.device                       ctl,
  // Decoded modes
  output var  logic                        serialMode,
  output var  logic                        skewPatternMode,
  output var  logic                        syncPatternMode,
  output var  logic                        globalPowerdown,
  output var  logic                        coarseGainOn,
  output var  logic                        extRefMode,
  output var  logic                        twoWireMode,
  output var  logic                        sdrClock,
  output var  logic                        ser14x,
  output var  logic                        captureFalling,
  output var  logic                        offsetBinary,
  output var  logic                        lsbFirst,
  // Serial register writes
  output var  logic                        regWrStrobe,
  output var  logic [`ADCP_ADDR_W-1:0]     regWrAddr,
  output var  logic [`ADCP_DATA_W-1:0]     regWrData,
  // Register read port
  input  wire logic [$clog2(REG_CNT)-1:0]  regRdAddr,
  output var  logic [`ADCP_DATA_W-1:0]     regRdData
);

  localparam int IDX_W = $clog2(REG_CNT);

  // ----------------------------------------------------------------
  // Decoding functions.
  // ----------------------------------------------------------------
  function automatic logic linkIsSdr(input logic [1:0] code);
    return (code == `ADCP_LINK_1W_SDR) || (code == `ADCP_LINK_2W_SDR);
  endfunction

  function automatic logic serIs14x(input logic [1:0] code);
    return (code == `ADCP_SER_14X_RISE) || (code == `ADCP_SER_14X_FALL);
  endfunction

  function automatic logic serIsFall(input logic [1:0] code);
    return (code == `ADCP_SER_14X_FALL) || (code == `ADCP_SER_12X_FALL);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic [`ADCP_PIN_W-1:0] pinRaw;
  logic [`ADCP_PIN_W-1:0] syncA_reg;
  logic [`ADCP_PIN_W-1:0] syncA_next;
  logic [`ADCP_PIN_W-1:0] syncB_reg;
  logic [`ADCP_PIN_W-1:0] syncB_next;
  logic                   sclkPrev_reg;
  logic                   sclkPrev_next;

  assign pinRaw = {ctl.fmtCfg, ctl.serCfg, ctl.linkCfg, ctl.powerdownPin,
                   ctl.serialEnable, ctl.serialData, ctl.serialClk, ctl.resetIn};

  always_comb begin
    syncA_next    = pinRaw;
    syncB_next    = syncA_reg;
    sclkPrev_next = syncB_reg[`ADCP_PIN_SCLK];
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syncA_reg    <= `ADCP_PIN_RSTV;
      syncB_reg    <= `ADCP_PIN_RSTV;
      sclkPrev_reg <= 1'b0;
    end else begin
      syncA_reg    <= syncA_next;
      syncB_reg    <= syncB_next;
      sclkPrev_reg <= sclkPrev_next;
    end
  end

  logic       rstLvl;
  logic       sclkLvl;
  logic       sdataLvl;
  logic       senLvl;
  logic       pdnLvl;
  logic [1:0] linkCode;
  logic [1:0] serCode;
  logic [1:0] fmtCode;
  logic       sclkRise;

  assign rstLvl   = syncB_reg[`ADCP_PIN_RST];
  assign sclkLvl  = syncB_reg[`ADCP_PIN_SCLK];
  assign sdataLvl = syncB_reg[`ADCP_PIN_SERIAL_DATA_IN];
  assign senLvl   = syncB_reg[`ADCP_PIN_SEN];
  assign pdnLvl   = syncB_reg[`ADCP_PIN_PDN];
  assign linkCode = syncB_reg[`ADCP_PIN_LINK +: 2];
  assign serCode  = syncB_reg[`ADCP_PIN_SER +: 2];
  assign fmtCode  = syncB_reg[`ADCP_PIN_FMT +: 2];
  assign sclkRise = sclkLvl & ~sclkPrev_reg;

  // ----------------------------------------------------------------
  // Serial programming receiver.
  // ----------------------------------------------------------------
  adcp_pkg::adcp_rx_state_t    rxState_reg;
  adcp_pkg::adcp_rx_state_t    rxState_next;
  logic [`ADCP_WORD_W-1:0]     shift_reg;
  logic [`ADCP_WORD_W-1:0]     shift_next;
  logic [`ADCP_CNT_W-1:0]      bitCnt_reg;
  logic [`ADCP_CNT_W-1:0]      bitCnt_next;
  logic [`ADCP_DATA_W-1:0]     regs_reg [REG_CNT];
  logic [`ADCP_DATA_W-1:0]     regs_next [REG_CNT];
  logic                        wrStb_next;
  logic [`ADCP_ADDR_W-1:0]     wrAddr_next;
  logic [`ADCP_DATA_W-1:0]     wrData_next;
  logic [`ADCP_ADDR_W-1:0]     rxAddr;
  logic [`ADCP_DATA_W-1:0]     rxData;

  assign rxAddr = shift_reg[`ADCP_WORD_W-1 -: `ADCP_ADDR_W];
  assign rxData = shift_reg[`ADCP_DATA_W-1:0];

  always_comb begin
    rxState_next = rxState_reg;
    shift_next   = shift_reg;
    bitCnt_next  = bitCnt_reg;
    regs_next    = regs_reg;
    wrStb_next   = 1'b0;
    wrAddr_next  = regWrAddr;
    wrData_next  = regWrData;
    if (rstLvl) begin
      // RL6: hardware reset clears.
      rxState_next = adcp_pkg::RX_IDLE;
      bitCnt_next  = '0;
      for (int i = 0; i < REG_CNT; i++) begin
        regs_next[i] = `ADCP_REG_RST;
      end
    end else begin
      unique case (rxState_reg)
        adcp_pkg::RX_IDLE: begin
          // RL3: enable opens frame.
          if (!senLvl) begin
            rxState_next = adcp_pkg::RX_SHIFT;
            bitCnt_next  = '0;
          end
        end
        adcp_pkg::RX_SHIFT: begin
          if (senLvl) begin
            rxState_next = adcp_pkg::RX_IDLE;
            if (bitCnt_reg == `ADCP_CNT_FULL) begin
              wrStb_next  = 1'b1;
              wrAddr_next = rxAddr;
              wrData_next = rxData;
              if (rxAddr == `ADCP_SW_RST_ADDR && rxData[`ADCP_SW_RST_BIT]) begin
                for (int i = 0; i < REG_CNT; i++) begin
                  regs_next[i] = `ADCP_REG_RST;
                end
              end else if (int'(rxAddr) < REG_CNT) begin
                regs_next[rxAddr[IDX_W-1:0]] = rxData;
              end
            end
          // RL1: shift on clock edge.
          end else if (sclkRise && bitCnt_reg != `ADCP_CNT_OVER) begin
            // RL2: data bit captured.
            shift_next  = {shift_reg[`ADCP_WORD_W-2:0], sdataLvl};
            bitCnt_next = bitCnt_reg + `ADCP_CNT_W'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxState_reg <= adcp_pkg::RX_IDLE;
      shift_reg   <= '0;
      bitCnt_reg  <= '0;
      regWrStrobe <= 1'b0;
      regWrAddr   <= '0;
      regWrData   <= '0;
      for (int i = 0; i < REG_CNT; i++) begin
        regs_reg[i] <= `ADCP_REG_RST;
      end
    end else begin
      rxState_reg <= rxState_next;
      shift_reg   <= shift_next;
      bitCnt_reg  <= bitCnt_next;
      regWrStrobe <= wrStb_next;
      regWrAddr   <= wrAddr_next;
      regWrData   <= wrData_next;
      regs_reg    <= regs_next;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode.
  // ----------------------------------------------------------------
  logic [1:0]              parCode;
  logic [`ADCP_DATA_W-1:0] modeReg;
  logic [11:0]             mode_next;
  logic [`ADCP_DATA_W-1:0] rd_next;
  logic                    parPdn;
  logic                    sdrSel;

  assign parCode = {sclkLvl, sdataLvl};
  assign modeReg = regs_reg[`ADCP_MODE_IDX];

  always_comb begin
    sdrSel = linkIsSdr(linkCode);
    if (rstLvl) begin
      // RL4: clock and data decode.
      mode_next[1] = (parCode == `ADCP_PAR_SKEW);
      mode_next[2] = (parCode == `ADCP_PAR_SYNC);
      parPdn       = (parCode == `ADCP_PAR_PDN);
      // RL5: enable level decode.
      mode_next[4] = ~senLvl;
      mode_next[5] = ~senLvl;
    end else begin
      mode_next[1] = modeReg[`ADCP_MODE_SKEW];
      mode_next[2] = modeReg[`ADCP_MODE_SYNC];
      parPdn       = modeReg[`ADCP_MODE_PDN];
      mode_next[4] = modeReg[`ADCP_MODE_GAIN];
      mode_next[5] = modeReg[`ADCP_MODE_EXTREF];
    end
    // RL14: role follows reset.
    mode_next[0]  = ~rstLvl;
    // RL12: pin forces power-down.
    mode_next[3]  = pdnLvl | parPdn;
    // RL8: link pin decode.
    // RL9: ground gives 1-wire DDR.
    mode_next[6]  = linkCode[1];
    mode_next[7]  = sdrSel;
    // RL10: factor and edge.
    mode_next[8]  = serIs14x(serCode);
    // RL11: DDR ignores edge level.
    mode_next[9]  = sdrSel & serIsFall(serCode);
    // RL13: format pin decode.
    mode_next[10] = fmtCode[`ADCP_FMT_OFFBIN];
    mode_next[11] = fmtCode[`ADCP_FMT_LSBFIRST];
    rd_next       = regs_reg[regRdAddr];
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {lsbFirst, offsetBinary, captureFalling, ser14x, sdrClock, twoWireMode,
       extRefMode, coarseGainOn, globalPowerdown, syncPatternMode,
       skewPatternMode, serialMode} <= 12'h001;
      regRdData <= '0;
    end else begin
      {lsbFirst, offsetBinary, captureFalling, ser14x, sdrClock, twoWireMode,
       extRefMode, coarseGainOn, globalPowerdown, syncPatternMode,
       skewPatternMode, serialMode} <= mode_next;
      regRdData <= rd_next;
    end
  end

endmodule

`default_nettype wire

// [adcp_host_end.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adcp_defs.svh"

module adcp_host_end #(
  parameter int SCLK_HALF = `ADCP_SCLK_HALF_CYC,
  parameter int RST_CYC   = `ADCP_RST_CYC
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  // Register port
  input  wire logic [`ADCP_BUS_AW-1:0]  busAddr,
  input  wire logic [`ADCP_BUS_DW-1:0]  busWrData,
  input  wire logic                     busWrStb,
  input  wire logic                     busRdStb,
  output var  logic [`ADCP_BUS_DW-1:0]  busRdData,
  // Control pins
  adcp_ctl_if.host                      ctl
);

  // ----------------------------------------------------------------
  // Command registers and sequencer.
  // ----------------------------------------------------------------
  adcp_pkg::adcp_host_state_t state_reg;
  adcp_pkg::adcp_host_state_t state_next;
  logic [`ADCP_CTRL_W-1:0]    ctrl_reg;
  logic [`ADCP_CTRL_W-1:0]    ctrl_next;
  logic [`ADCP_STRAP_W-1:0]   strap_reg;
  logic [`ADCP_STRAP_W-1:0]   strap_next;
  logic [`ADCP_WORD_W-1:0]    word_reg;
  logic [`ADCP_WORD_W-1:0]    word_next;
  logic [`ADCP_TMR_W-1:0]     tmr_reg;
  logic [`ADCP_TMR_W-1:0]     tmr_next;
  logic [`ADCP_CNT_W-1:0]     bits_reg;
  logic [`ADCP_CNT_W-1:0]     bits_next;
  logic [`ADCP_BUS_DW-1:0]    rd_next;
  logic [`ADCP_PIN_W-1:0]     pins_reg;
  logic [`ADCP_PIN_W-1:0]     pins_next;
  logic                       wrCtrl;
  logic                       wrStrap;
  logic                       tmrDone;
  logic                       busy;
  logic                       parMode;
  logic                       inFrame;

  assign wrCtrl  = busWrStb && busAddr == `ADCP_HREG_CTRL;
  assign wrStrap = busWrStb && busAddr == `ADCP_HREG_STRAP;
  assign tmrDone = (tmr_reg == '0);
  assign busy    = (state_reg != adcp_pkg::HS_IDLE);
  assign parMode = ctrl_reg[0];
  assign inFrame = (state_reg == adcp_pkg::HS_LEAD) || (state_reg == adcp_pkg::HS_LOW)
                   || (state_reg == adcp_pkg::HS_HIGH);

  always_comb begin
    state_next = state_reg;
    ctrl_next  = wrCtrl ? busWrData[`ADCP_CTRL_W-1:0] : ctrl_reg;
    strap_next = wrStrap ? busWrData[`ADCP_STRAP_W-1:0] : strap_reg;
    word_next  = word_reg;
    bits_next  = bits_reg;
    tmr_next   = tmrDone ? tmr_reg : tmr_reg - `ADCP_TMR_W'(1);
    unique case (state_reg)
      adcp_pkg::HS_PULSE: begin
        if (tmrDone) begin
          state_next = adcp_pkg::HS_IDLE;
        end
      end
      adcp_pkg::HS_IDLE: begin
        if (busWrStb && busAddr == `ADCP_HREG_CMD && !parMode) begin
          state_next = adcp_pkg::HS_LEAD;
          word_next  = busWrData[`ADCP_WORD_W-1:0];
          bits_next  = `ADCP_CNT_FULL;
          tmr_next   = `ADCP_TMR_W'(SCLK_HALF - 1);
        end else if (busWrStb && busAddr == `ADCP_HREG_RESET && busWrData[0]) begin
          state_next = adcp_pkg::HS_PULSE;
          tmr_next   = `ADCP_TMR_W'(RST_CYC - 1);
        end
      end
      adcp_pkg::HS_LEAD: begin
        if (tmrDone) begin
          state_next = adcp_pkg::HS_LOW;
          tmr_next   = `ADCP_TMR_W'(SCLK_HALF - 1);
        end
      end
      adcp_pkg::HS_LOW: begin
        if (tmrDone) begin
          state_next = adcp_pkg::HS_HIGH;
          tmr_next   = `ADCP_TMR_W'(SCLK_HALF - 1);
        end
      end
      adcp_pkg::HS_HIGH: begin
        if (tmrDone) begin
          word_next  = {word_reg[`ADCP_WORD_W-2:0], 1'b0};
          bits_next  = bits_reg - `ADCP_CNT_W'(1);
          state_next = (bits_reg == `ADCP_CNT_W'(1)) ? adcp_pkg::HS_TAIL : adcp_pkg::HS_LOW;
          tmr_next   = `ADCP_TMR_W'(SCLK_HALF - 1);
        end
      end
      adcp_pkg::HS_TAIL: begin
        if (tmrDone) begin
          state_next = adcp_pkg::HS_IDLE;
        end
      end
    endcase
    // RL7: parallel mode holds reset high.
    // RL6: serial mode pulses reset.
    pins_next[`ADCP_PIN_RST]   = ctrl_next[0] | (state_next == adcp_pkg::HS_PULSE);
    pins_next[`ADCP_PIN_SCLK]  = ctrl_next[0] ? ctrl_next[2] : (state_next == adcp_pkg::HS_HIGH);
    pins_next[`ADCP_PIN_SERIAL_DATA_IN] = ctrl_next[0] ? ctrl_next[1] : word_next[`ADCP_WORD_W-1];
    pins_next[`ADCP_PIN_SEN]   = ctrl_next[0] ? ctrl_next[3] :
                                 !((state_next == adcp_pkg::HS_LEAD) ||
                                   (state_next == adcp_pkg::HS_LOW) ||
                                   (state_next == adcp_pkg::HS_HIGH));
    // RL9: strap defaults to ground.
    // RL11: either level for DDR 12x.
    pins_next[`ADCP_PIN_PDN]   = strap_next[6];
    pins_next[`ADCP_PIN_LINK +: 2] = strap_next[1:0];
    pins_next[`ADCP_PIN_SER +: 2]  = strap_next[3:2];
    pins_next[`ADCP_PIN_FMT +: 2]  = strap_next[5:4];
    rd_next = '0;
    if (busRdStb) begin
      unique case (busAddr)
        `ADCP_HREG_CTRL:   rd_next = `ADCP_BUS_DW'(ctrl_reg);
        `ADCP_HREG_STRAP:  rd_next = `ADCP_BUS_DW'(strap_reg);
        `ADCP_HREG_CMD:    rd_next = `ADCP_BUS_DW'(word_reg);
        `ADCP_HREG_STATUS: rd_next = `ADCP_BUS_DW'({inFrame, busy});
        default:           rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= adcp_pkg::HS_PULSE;
      ctrl_reg  <= `ADCP_CTRL_RST;
      strap_reg <= `ADCP_STRAP_RST;
      word_reg  <= '0;
      bits_reg  <= '0;
      tmr_reg   <= `ADCP_TMR_W'(RST_CYC - 1);
      pins_reg  <= `ADCP_PIN_RSTV;
      busRdData <= '0;
    end else begin
      state_reg <= state_next;
      ctrl_reg  <= ctrl_next;
      strap_reg <= strap_next;
      word_reg  <= word_next;
      bits_reg  <= bits_next;
      tmr_reg   <= tmr_next;
      pins_reg  <= pins_next;
      busRdData <= rd_next;
    end
  end

  assign ctl.resetIn      = pins_reg[`ADCP_PIN_RST];
  assign ctl.serialClk    = pins_reg[`ADCP_PIN_SCLK];
  assign ctl.serialData   = pins_reg[`ADCP_PIN_SERIAL_DATA_IN];
  assign ctl.serialEnable = pins_reg[`ADCP_PIN_SEN];
  assign ctl.powerdownPin = pins_reg[`ADCP_PIN_PDN];
  assign ctl.linkCfg      = pins_reg[`ADCP_PIN_LINK +: 2];
  assign ctl.serCfg       = pins_reg[`ADCP_PIN_SER +: 2];
  assign ctl.fmtCfg       = pins_reg[`ADCP_PIN_FMT +: 2];

endmodule

`default_nettype wire

// [adcp_ctl_monitor.sv]
`timescale 1ns/10ps
`default_nettype none

module adcp_ctl_monitor (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // Control pins
  input wire logic       resetIn,
  input wire logic       serialClk,
  input wire logic       serialData,
  input wire logic       serialEnable,
  input wire logic       powerdownPin,
  input wire logic [1:0] linkCfg,
  input wire logic [1:0] serCfg,
  input wire logic [1:0] fmtCfg
);
  // ----------------------------------------------------------------
  // Serial clock rising edges counted within a frame.
  // ----------------------------------------------------------------
  logic [4:0] frameCnt_reg;
  logic [4:0] frameCnt_next;
  logic       clkPrev_reg;
  logic       clkPrev_next;

  always_comb begin
    frameCnt_next = frameCnt_reg;
    clkPrev_next  = serialClk;
    if (serialEnable || resetIn) begin
      frameCnt_next = 5'h00;
    end else if (serialClk && !clkPrev_reg) begin
      frameCnt_next = frameCnt_reg + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      frameCnt_reg <= 5'h00;
      clkPrev_reg  <= 1'b0;
    end else begin
      frameCnt_reg <= frameCnt_next;
      clkPrev_reg  <= clkPrev_next;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_pulse_min_len:
    assert property ($rose(resetIn) |-> resetIn[*8]) else $error("reset pulse too short");
  a_frame_no_reset:
    assert property (!serialEnable && $past(serialEnable) == 1'b0 && !resetIn |=> !resetIn)
    else $error("reset level rose inside a frame");
  a_lead_quiet:
    assert property ($fell(serialEnable) && !resetIn |-> (!serialEnable && !serialClk)[*8])
    else $error("frame lead too short");
  a_clk_high_len:
    assert property ($rose(serialClk) && !resetIn |-> serialClk[*4] ##1 !serialClk)
    else $error("serial clock high time wrong");
  a_clk_low_len:
    assert property ($fell(serialClk) && !resetIn && !serialEnable |-> !serialClk[*4])
    else $error("serial clock low time wrong");
  a_data_hold:
    assert property (serialClk && !resetIn && $past(resetIn) == 1'b0 |-> $stable(serialData))
    else $error("serial data moved while clock high");
  a_frame_bits:
    assert property ($rose(serialEnable) && !resetIn && frameCnt_reg != 5'h00
                     |-> frameCnt_reg == 5'h10) else $error("frame bit count wrong");
  a_idle_clk_low:
    assert property (serialEnable && !resetIn && $past(resetIn) == 1'b0 |-> !serialClk)
    else $error("serial clock moved outside frame");

  cover property ($rose(resetIn));
  cover property ($rose(serialEnable) && frameCnt_reg == 5'h10);
  cover property (resetIn && serialClk && serialData);
endmodule

`default_nettype wire

// [test_adc_control_pin_mode_select.sv]
`timescale 1ns/10ps
`default_nettype none
`include "adcp_defs.svh"
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin nMismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end

module test_adc_control_pin_mode_select;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  busAddr = 4'h0;
  logic [31:0] busWrData = 32'h0;
  logic        busWrStb = 1'b0;
  logic        busRdStb = 1'b0;
  logic [31:0] busRdData;
  logic [2:0]  regRdAddr = 3'h0;
  logic [7:0]  regRdData;
  logic        wrStb;
  logic [7:0]  wrAddr;
  logic [7:0]  wrData;
  wire  [11:0] modes;
  logic [31:0] lfsr = 32'hb1d388d5;
  logic [31:0] rd;
  logic [3:0]  ctrl = 4'h0;
  logic [6:0]  strap = 7'h00;
  logic [4:0]  mreg = 5'h00;
  int          nMismatch = 0;
  int          nTests = 0;
  int          nWr = 0;

  always #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (wrStb === 1'b1) nWr <= nWr + 1;
  end

  adcp_ctl_if adcp_ctl_if_i ();
  adcp_host_end adcp_host_end_i (.ref_clk(ref_clk), .rstn(rstn), .busAddr(busAddr),
    .busWrData(busWrData), .busWrStb(busWrStb), .busRdStb(busRdStb),
    .busRdData(busRdData), .ctl(adcp_ctl_if_i.host));
  adcp_dev_end adcp_dev_end_i (.ref_clk(ref_clk), .rstn(rstn), .ctl(adcp_ctl_if_i.device),
    .serialMode(modes[11]), .skewPatternMode(modes[10]), .syncPatternMode(modes[9]),
    .globalPowerdown(modes[8]), .coarseGainOn(modes[7]), .extRefMode(modes[6]),
    .twoWireMode(modes[5]), .sdrClock(modes[4]), .ser14x(modes[3]),
    .captureFalling(modes[2]), .offsetBinary(modes[1]), .lsbFirst(modes[0]),
    .regWrStrobe(wrStb), .regWrAddr(wrAddr), .regWrData(wrData), .regRdAddr(regRdAddr),
    .regRdData(regRdData));
  adcp_ctl_monitor adcp_ctl_monitor_i (.ref_clk(ref_clk), .rstn(rstn),
    .resetIn(adcp_ctl_if_i.resetIn), .serialClk(adcp_ctl_if_i.serialClk),
    .serialData(adcp_ctl_if_i.serialData), .serialEnable(adcp_ctl_if_i.serialEnable),
    .powerdownPin(adcp_ctl_if_i.powerdownPin), .linkCfg(adcp_ctl_if_i.linkCfg),
    .serCfg(adcp_ctl_if_i.serCfg), .fmtCfg(adcp_ctl_if_i.fmtCfg));

  // ----------------------------------------------------------------
  // Expected values and bus tasks.
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsrNext(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [11:0] expModes(logic [3:0] c, logic [6:0] s, logic [4:0] r);
    logic [4:0] m;
    logic       sdr;
    m = c[0] ? {~c[3], ~c[3], c[2] & c[1], c[2] & ~c[1], ~c[2] & c[1]} : r;
    sdr = s[1] ^ s[0];
    return {~c[0], m[0], m[1], m[2] | s[6], m[3], m[4], s[1], sdr, s[3] ^ s[2],
            sdr & s[3], s[4], s[5]};
  endfunction

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    busAddr <= a;
    busWrData <= d;
    busWrStb <= 1'b1;
    @(posedge ref_clk);
    busWrStb <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a);
    @(posedge ref_clk);
    busAddr <= a;
    busRdStb <= 1'b1;
    @(posedge ref_clk);
    busRdStb <= 1'b0;
    #1 rd = busRdData;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 200) begin
      bus_rd(`ADCP_HREG_STATUS);
      n++;
    end
    if (n >= 200) nMismatch++;
  endtask

  task automatic send_cmd(input logic [15:0] w);
    bus_wr(`ADCP_HREG_CMD, {16'h0, w});
    wait_idle();
    repeat (2) @(posedge ref_clk);
    #1 `CHK({wrAddr, wrData}, w)
  endtask

  task automatic check_modes();
    repeat (6) @(posedge ref_clk);
    #1 `CHK(modes, expModes(ctrl, strap, mreg))
  endtask

  task automatic read_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regRdAddr <= a;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(regRdData, e)
  endtask

  task automatic finalReport();
    $display("mismatches %0d, comparisons %0d", nMismatch, nTests);
    if (nMismatch == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    finalReport();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (7) @(posedge ref_clk);
    #1 `CHK(modes[11], 1'b0)
    wait_idle();
    check_modes();
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsrNext(lfsr);
      strap = {lfsr[6:4], i[3:0]};
      bus_wr(`ADCP_HREG_STRAP, {25'h0, strap});
      check_modes();
      bus_rd(`ADCP_HREG_STRAP);
      `CHK(rd, {25'h0, strap})
    end
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsrNext(lfsr);
      mreg = lfsr[4:0];
      send_cmd({8'h01, 3'h0, mreg});
      send_cmd({8'h05, lfsr[15:8]});
      check_modes();
      read_reg(3'h5, lfsr[15:8]);
    end
    send_cmd(16'h0001);
    mreg = 5'h00;
    check_modes();
    read_reg(3'h5, 8'h00);
    send_cmd(16'h011f);
    bus_wr(`ADCP_HREG_RESET, 32'h1);
    wait_idle();
    check_modes();
    send_cmd(16'h010a);
    mreg = 5'h0a;
    check_modes();
    for (int c = 7; c >= 0; c--) begin
      ctrl = {c[2:0], 1'b1};
      bus_wr(`ADCP_HREG_CTRL, {28'h0, ctrl});
      check_modes();
      bus_rd(`ADCP_HREG_CTRL);
      `CHK(rd, {28'h0, ctrl})
    end
    ctrl = 4'h0;
    mreg = 5'h00;
    bus_wr(`ADCP_HREG_CTRL, 32'h0);
    check_modes();
    bus_rd(4'hf);
    `CHK(rd, 32'h0)
    `CHK(nWr, 11)
    finalReport();
  end
endmodule

`default_nettype wire
